// ===== ccr_clock_radio.sv
// Calendar clock radio timekeeping, alarm, sleep and display control
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_radio #(
  parameter bit TWELVE_HOUR = 1'b1,
  parameter int TONE_HALF = ccr_pkg::TONE_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic line_clock_input,
  input wire logic line_rate_select,
  input wire logic power_dip,
  input wire logic view_set_low,
  input wire logic view_set_high,
  input wire logic advance_low,
  input wire logic advance_high,
  input wire logic mode_low,
  input wire logic mode_high,
  input wire logic arm_low,
  input wire logic arm_high,
  output logic [7:0] disp_left_q,
  output logic [7:0] disp_right_q,
  output logic left_blank_q,
  output logic right_blank_q,
  output logic colon_q,
  output logic afternoon_indicator,
  output logic ap_letter_q,
  output logic alarm_on_ind_q,
  output logic tone_out_q,
  output logic sleep_out_q
);
  import ccr_pkg::*;

  localparam int TW = $clog2(TONE_HALF + 1);

  if (TONE_HALF < 1) begin : g_tone_check
    $error("ccr_clock_radio: TONE_HALF must be >= 1");
  end

  function automatic logic [7:0] to_bcd(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'd10;
    return {t[3:0], 4'(v - 7'(t * 7'd10))};
  endfunction

  function automatic logic [4:0] days_in(input logic [3:0] m,
                                         input logic [1:0] yr);
    if (m == 4'h2) return (yr == 2'h0) ? 5'h1D : 5'h1C;
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) return 5'h1E;
    return 5'h1F;
  endfunction

  // Line edge, prescaler and tone
  logic line_prev_q, line_prev_d;
  logic [5:0] pre_q, pre_d, div;
  logic [TW-1:0] tone_cnt_q, tone_cnt_d;
  logic tone_sq_q, tone_sq_d;
  logic line_tick, tick1, tick2, blink1, blink2;

  assign div = line_rate_select ? LINE_DIV_50 : LINE_DIV_60;
  assign line_tick = line_clock_input & ~line_prev_q;
  assign tick1 = line_tick && (pre_q == div - 6'h01);
  assign tick2 = tick1 || (line_tick && pre_q == (div >> 1) - 6'h01);
  assign blink1 = pre_q < (div >> 1);
  assign blink2 = (pre_q < (div >> 2)) ||
                  ((pre_q >= (div >> 1)) && (pre_q < div - (div >> 2)));

  always_comb begin
    line_prev_d = line_clock_input;
    pre_d = pre_q;
    if (line_tick) pre_d = tick1 ? 6'h00 : pre_q + 6'h01;
    tone_cnt_d = tone_cnt_q + 1'b1;
    tone_sq_d = tone_sq_q;
    if (tone_cnt_q == TW'(TONE_HALF - 1)) begin
      tone_cnt_d = '0;
      tone_sq_d = ~tone_sq_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_prev_q <= 1'b0;
      pre_q <= 6'h00;
      tone_cnt_q <= '0;
      tone_sq_q <= 1'b0;
    end else begin
      line_prev_q <= line_prev_d;
      pre_q <= pre_d;
      tone_cnt_q <= tone_cnt_d;
      tone_sq_q <= tone_sq_d;
    end
  end

  // Switch decoding
  logic test_mode, disabled, arm_open;
  logic [6:0] hold_limit;
  logic avs_p, avs_long, adv_p, adv_long, seq_p, slp_p, slp_long;
  logic avs_lv, adv_lv, seq_lv, slp_lv;

  assign test_mode = view_set_high & advance_high;
  assign disabled = view_set_high & ~advance_high;
  assign arm_open = ~arm_low & ~arm_high;
  assign hold_limit = 7'(div) << HOLD_SECONDS - 1;
  assign avs_lv = view_set_low & ~view_set_high;
  assign adv_lv = advance_low & ~view_set_high;
  assign seq_lv = mode_low & ~view_set_high;
  assign slp_lv = mode_high & ~view_set_high;

  ccr_key_timer #(.CW(7)) u_key_avs (.clk(clk), .rst_b(rst_b),
    .level(avs_lv), .line_tick(line_tick), .limit(hold_limit),
    .press_p(avs_p), .held_long(avs_long));
  ccr_key_timer #(.CW(7)) u_key_adv (.clk(clk), .rst_b(rst_b),
    .level(adv_lv), .line_tick(line_tick), .limit(hold_limit),
    .press_p(adv_p), .held_long(adv_long));
  ccr_key_timer #(.CW(7)) u_key_seq (.clk(clk), .rst_b(rst_b),
    .level(seq_lv), .line_tick(line_tick), .limit(hold_limit),
    .press_p(seq_p), .held_long());
  ccr_key_timer #(.CW(7)) u_key_slp (.clk(clk), .rst_b(rst_b),
    .level(slp_lv), .line_tick(line_tick), .limit(hold_limit),
    .press_p(slp_p), .held_long(slp_long));

  // Time, calendar and setting sequencer
  ccr_seq_t seq_q, seq_d;
  logic [5:0] sec_q, sec_d, min_q, min_d;
  logic [4:0] hour_q, hour_d, day_q, day_d;
  logic [3:0] month_q, month_d, idle_q, idle_d;
  logic [1:0] year_q, year_d;
  logic min_set_q, min_set_d, minute_tick, in_set;

  assign in_set = seq_q != CCR_RUN && seq_q != CCR_HOLD;

  always_comb begin
    logic inc_min, inc_day, adj;
    inc_min = 1'b0;
    inc_day = 1'b0;
    adj = in_set && adv_lv && tick2;
    seq_d = seq_q;
    sec_d = sec_q;
    min_d = min_q;
    hour_d = hour_q;
    day_d = day_q;
    month_d = month_q;
    year_d = year_q;
    idle_d = idle_q;
    min_set_d = min_set_q;
    if (tick1 && seq_q != CCR_HOLD && !disabled) begin
      if (advance_high) begin
        inc_min = 1'b1;
      end else if (sec_q == MIN_SEC_MAX) begin
        sec_d = 6'h00;
        inc_min = 1'b1;
      end else begin
        sec_d = sec_q + 6'h01;
      end
    end
    if (inc_min) begin
      min_d = (min_q == MIN_SEC_MAX) ? 6'h00 : min_q + 6'h01;
      if (min_q == MIN_SEC_MAX) begin
        hour_d = (hour_q == HOUR_MAX) ? 5'h00 : hour_q + 5'h01;
        inc_day = hour_q == HOUR_MAX;
      end
    end
    if (inc_day || (adj && seq_q == (TWELVE_HOUR ? CCR_SET_RIGHT
                                                 : CCR_SET_LEFT))) begin
      day_d = (day_q >= days_in(month_q, year_q)) ? 5'h01 : day_q + 5'h01;
      if (inc_day && day_q >= days_in(month_q, year_q)) begin
        month_d = (month_q == MONTH_MAX) ? 4'h1 : month_q + 4'h1;
        if (month_q == MONTH_MAX) year_d = year_q + 2'h1;
      end
    end
    if (adj && seq_q == (TWELVE_HOUR ? CCR_SET_LEFT : CCR_SET_RIGHT)) begin
      month_d = (month_q == MONTH_MAX) ? 4'h1 : month_q + 4'h1;
    end
    if (adj && seq_q == CCR_SET_HR) begin
      hour_d = (hour_q == HOUR_MAX) ? 5'h00 : hour_q + 5'h01;
    end
    if (adj && seq_q == CCR_SET_MIN) begin
      min_d = (min_q == MIN_SEC_MAX) ? 6'h00 : min_q + 6'h01;
      sec_d = 6'h00;
      min_set_d = 1'b1;
    end
    if (in_set) begin
      if (adj) idle_d = 4'h0;
      else if (tick1 && idle_q != IDLE_SECONDS) idle_d = idle_q + 4'h1;
    end else begin
      idle_d = 4'h0;
    end
    if (seq_p) begin
      idle_d = 4'h0;
      unique case (seq_q)
        CCR_RUN: begin
          seq_d = CCR_SET_HR;
          min_set_d = 1'b0;
        end
        CCR_SET_HR: seq_d = CCR_SET_MIN;
        CCR_SET_MIN: seq_d = CCR_SET_LEFT;
        CCR_SET_LEFT: seq_d = CCR_SET_RIGHT;
        CCR_SET_RIGHT: seq_d = min_set_q ? CCR_HOLD : CCR_RUN;
        CCR_HOLD: seq_d = CCR_RUN;
      endcase
    end else if (in_set && idle_q == IDLE_SECONDS) begin
      seq_d = min_set_q ? CCR_HOLD : CCR_RUN;
    end
    minute_tick = inc_min;
    if (test_mode) begin
      seq_d = CCR_RUN;
      sec_d = 6'h00;
      min_d = TEST_MIN;
      hour_d = TEST_HOUR;
      month_d = TEST_MONTH;
      day_d = TEST_DAY;
      minute_tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= CCR_RUN;
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hour_q <= 5'h00;
      day_q <= RESET_DAY;
      month_q <= RESET_MONTH;
      year_q <= 2'h0;
      idle_q <= 4'h0;
      min_set_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      sec_q <= sec_d;
      min_q <= min_d;
      hour_q <= hour_d;
      day_q <= day_d;
      month_q <= month_d;
      year_q <= year_d;
      idle_q <= idle_d;
      min_set_q <= min_set_d;
    end
  end

  // Alarm, snooze, sleep, power dip and view timer
  logic [5:0] al_min_q, al_min_d, latch_min_q, latch_min_d;
  logic [5:0] sleep_cnt_q, sleep_cnt_d;
  logic [4:0] al_hr_q, al_hr_d;
  logic [3:0] snooze_min_q, snooze_min_d;
  logic latch_q, latch_d, snooze_q, snooze_d, sleep_q, sleep_d;
  logic pf_q, pf_d, outs_active, fast;
  ccr_view_t view_q, view_d;
  logic [6:0] view_cnt_q, view_cnt_d;

  assign outs_active = (latch_q & ~arm_open) | sleep_q;
  assign fast = adv_lv ? line_tick : tick2;

  always_comb begin
    al_min_d = al_min_q;
    al_hr_d = al_hr_q;
    latch_d = latch_q;
    latch_min_d = latch_min_q;
    snooze_d = snooze_q;
    snooze_min_d = snooze_min_q;
    sleep_d = sleep_q;
    sleep_cnt_d = sleep_cnt_q;
    pf_d = pf_q;
    view_d = view_q;
    view_cnt_d = (line_tick && view_cnt_q != 7'h00) ? view_cnt_q - 7'h01
                                                   : view_cnt_q;
    if (view_cnt_q == 7'h00 && !avs_lv && !slp_lv && !adv_lv)
      view_d = CCR_V_NONE;
    if (latch_q && minute_tick) begin
      latch_min_d = latch_min_q + 6'h01;
      if (latch_min_q == LATCH_MINUTES - 6'h01) latch_d = 1'b0;
    end
    if (snooze_q && minute_tick) begin
      snooze_min_d = snooze_min_q + 4'h1;
      if (snooze_min_q == SNOOZE_MINUTES - 4'h1) snooze_d = 1'b0;
    end
    if (sleep_q && minute_tick) begin
      sleep_cnt_d = (sleep_cnt_q == 6'h00) ? 6'h00 : sleep_cnt_q - 6'h01;
      if (sleep_cnt_q <= 6'h01) sleep_d = 1'b0;
    end
    if (minute_tick && !arm_open && hour_d == al_hr_q &&
        min_d == al_min_q) begin
      latch_d = 1'b1;
      latch_min_d = 6'h00;
    end
    if (arm_open && !disabled) begin
      latch_d = 1'b0;
      snooze_d = 1'b0;
    end
    if (!latch_d) snooze_d = 1'b0;
    if (avs_p) begin
      view_cnt_d = hold_limit;
      if (pf_q) begin
        pf_d = 1'b0;
        view_d = CCR_V_ALARM;
      end else if (outs_active) begin
        snooze_d = latch_q;
        snooze_min_d = 4'h0;
        sleep_d = 1'b0;
      end else begin
        view_d = CCR_V_ALARM;
      end
    end
    if (avs_long && view_q == CCR_V_ALARM && fast) begin
      view_cnt_d = hold_limit;
      al_min_d = (al_min_q == MIN_SEC_MAX) ? 6'h00 : al_min_q + 6'h01;
      if (al_min_q == MIN_SEC_MAX)
        al_hr_d = (al_hr_q == HOUR_MAX) ? 5'h00 : al_hr_q + 5'h01;
    end
    if (slp_p) begin
      view_d = CCR_V_SLEEP;
      view_cnt_d = hold_limit;
    end
    if (slp_long && fast) begin
      view_cnt_d = hold_limit;
      sleep_cnt_d = (sleep_cnt_q == 6'h00) ? MIN_SEC_MAX
                                           : sleep_cnt_q - 6'h01;
      sleep_d = 1'b1;
    end
    if (adv_p && seq_q == CCR_RUN && view_q == CCR_V_NONE) begin
      view_d = CCR_V_DATE;
      view_cnt_d = hold_limit;
    end
    if (power_dip) pf_d = 1'b1;
    if (test_mode) begin
      al_min_d = TEST_MIN;
      al_hr_d = TEST_HOUR;
      sleep_cnt_d = 6'h00;
      sleep_d = 1'b0;
      latch_d = 1'b0;
      snooze_d = 1'b0;
      view_d = CCR_V_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      al_min_q <= 6'h00;
      al_hr_q <= 5'h00;
      latch_q <= 1'b0;
      latch_min_q <= 6'h00;
      snooze_q <= 1'b0;
      snooze_min_q <= 4'h0;
      sleep_q <= 1'b0;
      sleep_cnt_q <= 6'h00;
      pf_q <= 1'b1;
      view_q <= CCR_V_NONE;
      view_cnt_q <= 7'h00;
    end else begin
      al_min_q <= al_min_d;
      al_hr_q <= al_hr_d;
      latch_q <= latch_d;
      latch_min_q <= latch_min_d;
      snooze_q <= snooze_d;
      snooze_min_q <= snooze_min_d;
      sleep_q <= sleep_d;
      sleep_cnt_q <= sleep_cnt_d;
      pf_q <= pf_d;
      view_q <= view_d;
      view_cnt_q <= view_cnt_d;
    end
  end

  // Display and output drive
  logic [7:0] left_d, right_d;
  logic lb_d, rb_d, colon_d, pm_d, ap_d, ind_d, tone_d, sleep_o_d;

  always_comb begin
    logic [4:0] h, h12;
    h = (view_q == CCR_V_ALARM) ? al_hr_q : hour_q;
    h12 = (h > 5'h0C) ? h - 5'h0C : ((h == 5'h00) ? 5'h0C : h);
    left_d = to_bcd(7'(TWELVE_HOUR ? h12 : h));
    right_d = to_bcd(7'((view_q == CCR_V_ALARM) ? al_min_q : min_q));
    lb_d = 1'b0;
    rb_d = 1'b0;
    colon_d = blink1;
    pm_d = TWELVE_HOUR && h >= 5'h0C;
    ap_d = 1'b0;
    ind_d = ~arm_open;
    tone_d = latch_q & arm_low & ~snooze_q & blink2 & tone_sq_q;
    sleep_o_d = sleep_q | (latch_q & ~arm_open);
    unique case (view_q)
      CCR_V_ALARM: colon_d = 1'b1;
      CCR_V_SLEEP: begin
        lb_d = 1'b1;
        right_d = to_bcd(7'(sleep_cnt_q));
        pm_d = 1'b0;
      end
      CCR_V_DATE: begin
        left_d = to_bcd(7'(TWELVE_HOUR ? {3'h0, month_q} : {2'h0, day_q}));
        right_d = to_bcd(7'(TWELVE_HOUR ? {2'h0, day_q} : {3'h0, month_q}));
        colon_d = 1'b0;
        pm_d = 1'b0;
      end
      CCR_V_NONE: begin
        unique case (seq_q)
          CCR_RUN: ;
          CCR_SET_HR: begin
            rb_d = 1'b1;
            colon_d = 1'b1;
            ap_d = TWELVE_HOUR;
          end
          CCR_SET_MIN: begin
            lb_d = 1'b1;
            colon_d = 1'b1;
          end
          CCR_SET_LEFT: begin
            left_d = to_bcd(7'(TWELVE_HOUR ? {3'h0, month_q}
                                           : {2'h0, day_q}));
            rb_d = 1'b1;
            colon_d = 1'b0;
            pm_d = 1'b0;
          end
          CCR_SET_RIGHT: begin
            right_d = to_bcd(7'(TWELVE_HOUR ? {2'h0, day_q}
                                            : {3'h0, month_q}));
            lb_d = 1'b1;
            colon_d = 1'b0;
            pm_d = 1'b0;
          end
          CCR_HOLD: begin
            lb_d = ~blink2;
            rb_d = ~blink2;
            colon_d = blink2;
          end
        endcase
        if (pf_q) begin
          lb_d = ~blink2;
          rb_d = ~blink2;
          colon_d = 1'b0;
        end
      end
    endcase
    if (disabled) begin
      lb_d = 1'b1;
      rb_d = 1'b1;
      {colon_d, pm_d, ap_d, ind_d, tone_d, sleep_o_d} = 6'h00;
    end
    if (test_mode) begin
      lb_d = 1'b0;
      rb_d = 1'b0;
      {colon_d, pm_d, ap_d, ind_d, tone_d, sleep_o_d} = 6'h3F;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_left_q <= 8'h00;
      disp_right_q <= 8'h00;
      left_blank_q <= 1'b1;
      right_blank_q <= 1'b1;
      colon_q <= 1'b0;
      afternoon_indicator <= 1'b0;
      ap_letter_q <= 1'b0;
      alarm_on_ind_q <= 1'b0;
      tone_out_q <= 1'b0;
      sleep_out_q <= 1'b0;
    end else begin
      disp_left_q <= left_d;
      disp_right_q <= right_d;
      left_blank_q <= lb_d;
      right_blank_q <= rb_d;
      colon_q <= colon_d;
      afternoon_indicator <= pm_d;
      ap_letter_q <= ap_d;
      alarm_on_ind_q <= ind_d;
      tone_out_q <= tone_d;
      sleep_out_q <= sleep_o_d;
    end
  end
endmodule
`default_nettype wire

// ===== ccr_clock_radio_properties.sv
// Concurrent checks on the clock radio ports
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_radio_properties #(
  parameter bit TWELVE_HOUR = 1'b1,
  parameter int TONE_HALF = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic view_set_low,
  input wire logic view_set_high,
  input wire logic advance_high,
  input wire logic arm_low,
  input wire logic arm_high,
  input wire logic [7:0] disp_left_q,
  input wire logic [7:0] disp_right_q,
  input wire logic right_blank_q,
  input wire logic colon_q,
  input wire logic ap_letter_q,
  input wire logic alarm_on_ind_q,
  input wire logic tone_out_q,
  input wire logic sleep_out_q
);
  logic tone_prev_q;
  logic tone_prev_d;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Length of the current tone level, and time since disable/test
  always_comb begin
    tone_prev_d = tone_out_q;
    run_d = (tone_out_q != tone_prev_q) ? 8'h01 :
      run_q + {7'h00, run_q != 8'hFF};
    quiet_d = view_set_high ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tone_prev_q <= 1'b0;
      run_q <= 8'h00;
      quiet_q <= 4'h0;
    end else begin
      tone_prev_q <= tone_prev_d;
      run_q <= run_d;
      quiet_q <= quiet_d;
    end
  end
  a_disable_quiet: assert property (
    (view_set_high && !advance_high) [*3] |->
      !tone_out_q && !sleep_out_q && !colon_q)
    else $error("outputs active while disabled");
  a_test_outputs: assert property (
    (view_set_high && advance_high) [*3] |-> tone_out_q && sleep_out_q)
    else $error("test mode outputs off");
  a_test_time: assert property (
    (view_set_high && advance_high) [*5] |->
      disp_left_q == (TWELVE_HOUR ? 8'h12 : 8'h00) && disp_right_q == 8'h00)
    else $error("test mode time wrong");
  a_tone_needs_arm: assert property (
    (!arm_low && !(view_set_high && advance_high)) [*3] |-> !tone_out_q)
    else $error("tone without arm low");
  a_arm_indicator: assert property (
    (!view_set_high && $stable(arm_low) && $stable(arm_high)) [*3] |->
      alarm_on_ind_q == (arm_low || arm_high))
    else $error("arm indicator wrong");
  a_sleep_off_press: assert property (
    ($rose(view_set_low) && !view_set_high && !arm_low && !arm_high) |->
      ##[2:6] !sleep_out_q)
    else $error("sleep not cleared by press");
  a_tone_half: assert property (
    (tone_out_q && tone_prev_q && quiet_q == 4'hF) |->
      run_q < 8'(TONE_HALF))
    else $error("tone half period too long");
  a_hour_view: assert property (
    (ap_letter_q && !view_set_high && !$past(view_set_high)) |->
      right_blank_q && colon_q)
    else $error("hour set view wrong");
endmodule
`default_nettype wire

// ===== ccr_clock_radio_tb.sv
// Self-checking bench for the clock radio timekeeper
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_radio_tb;
  localparam int VS = 0;
  localparam int ADV = 1;
  localparam int MD = 2;
  localparam int ARM = 3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rate = 1'b0;
  logic dip = 1'b0;
  logic [1:0] pin [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
  wire line, vsl, vsh, advl, advh, ml, mh, al, ah;
  wire [7:0] dl;
  wire [7:0] dr;
  wire lb, rb, col, pm, ap, ind, tone, slp;
  int num_errors = 0;
  int checked = 0;
  initial forever #2.5 clk = ~clk;
  ccr_panel_model ccr_panel_model_inst (.clk(clk), .view_pin(pin[VS]),
    .adv_pin(pin[ADV]), .mode_pin(pin[MD]), .arm_pin(pin[ARM]),
    .line_clock_input(line), .view_set_low(vsl), .view_set_high(vsh),
    .advance_low(advl), .advance_high(advh), .mode_low(ml),
    .mode_high(mh), .arm_low(al), .arm_high(ah));
  ccr_clock_radio #(.TWELVE_HOUR(1'b1), .TONE_HALF(4)) ccr_clock_radio_inst (
    .clk(clk), .rst_b(rst_b), .line_clock_input(line),
    .line_rate_select(rate), .power_dip(dip), .view_set_low(vsl),
    .view_set_high(vsh), .advance_low(advl), .advance_high(advh),
    .mode_low(ml), .mode_high(mh), .arm_low(al), .arm_high(ah),
    .disp_left_q(dl), .disp_right_q(dr), .left_blank_q(lb),
    .right_blank_q(rb), .colon_q(col), .afternoon_indicator(pm),
    .ap_letter_q(ap), .alarm_on_ind_q(ind), .tone_out_q(tone),
    .sleep_out_q(slp));
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic press(input int k, input logic [1:0] c);
    pin[k] = c;
    cyc(2);
    pin[k] = 2'h0;
    cyc(4);
  endtask
  // Count blank toggles over n line edges, colon must stay dark
  task automatic blink(input int n, output int t);
    logic p;
    logic c;
    p = lb;
    c = 1'b0;
    t = 0;
    repeat (n * 8) begin
      cyc(1);
      t += int'(lb !== p);
      c |= col;
      p = lb;
    end
    chk({7'h00, c}, 8'h00);
  endtask
  task automatic t_power_fail;
    int t;
    cyc(16);
    blink(150, t);
    chk(8'(t), 8'h0A);
    rate = 1'b1;
    blink(120, t);
    blink(150, t);
    chk(8'(t), 8'h0C);
    rate = 1'b0;
    blink(120, t);
    press(VS, 2'h1);
    chk({7'h00, col}, 8'h01);
    chk(dl, 8'h12);
    chk(dr, 8'h00);
    cyc(1600);
    dip = 1'b1;
    cyc(1);
    dip = 1'b0;
    cyc(4);
    blink(60, t);
    chk(8'(t), 8'h04);
    press(VS, 2'h1);
    cyc(1600);
    $display("test power_fail done");
  endtask
  task automatic t_sequencer;
    logic [4:0] e [5];
    e = '{5'h0F, 5'h13, 5'h09, 5'h11, 5'h00};
    for (int i = 0; i < 5; i++) begin
      press(MD, 2'h1);
      chk({5'h00, lb, rb, ap}, {5'h00, e[i][4:2]});
      if (e[i][0]) begin
        chk({7'h00, col}, {7'h00, e[i][1]});
      end
      if (i == 2) begin
        chk(dl, 8'h01);
      end
      if (i == 3) begin
        chk(dr, 8'h01);
      end
      if (i == 0) begin
        pin[ADV] = 2'h1;
        cyc(2900);
        pin[ADV] = 2'h0;
        cyc(4);
        chk({7'h00, pm}, 8'h01);
      end
    end
    press(ADV, 2'h1);
    chk(dl, 8'h01);
    chk({7'h00, col}, 8'h00);
    $display("test sequencer done");
  endtask
  task automatic t_test_mode;
    pin[VS] = 2'h2;
    cyc(10);
    chk({5'h00, tone, slp, col}, 8'h00);
    pin[ADV] = 2'h2;
    cyc(10);
    chk({6'h00, tone, slp}, 8'h03);
    chk(dl, 8'h12);
    chk(dr, 8'h00);
    pin[VS] = 2'h0;
    pin[ADV] = 2'h0;
    cyc(1600);
    $display("test test_mode done");
  endtask
  task automatic t_alarm;
    int n;
    pin[ARM] = 2'h1;
    pin[VS] = 2'h1;
    for (n = 0; n < 3000 && dr !== 8'h01; n++) cyc(1);
    pin[VS] = 2'h0;
    chk(dr, 8'h01);
    cyc(1600);
    pin[ADV] = 2'h2;
    for (n = 0; n < 1000 && slp !== 1'b1; n++) cyc(1);
    pin[ADV] = 2'h0;
    chk({7'h00, slp}, 8'h01);
    n = 0;
    repeat (2000) begin
      cyc(1);
      n += int'(tone === 1'b1);
    end
    chk(8'(n > 0), 8'h01);
    pin[ARM] = 2'h2;
    cyc(10);
    chk({6'h00, tone, slp}, 8'h01);
    pin[ARM] = 2'h0;
    cyc(10);
    chk({6'h00, ind, slp}, 8'h00);
    pin[ARM] = 2'h1;
    cyc(10);
    chk({6'h00, ind, slp}, 8'h02);
    $display("test alarm done");
  endtask
  task automatic t_sleep;
    pin[ARM] = 2'h0;
    pin[MD] = 2'h2;
    cyc(1400);
    pin[MD] = 2'h0;
    cyc(4);
    chk({7'h00, slp}, 8'h01);
    cyc(1600);
    press(VS, 2'h1);
    chk({7'h00, slp}, 8'h00);
    $display("test sleep done");
  endtask
  initial begin
    cyc(4);
    chk(dl, 8'h00);
    chk({3'h0, lb, rb, col, tone, slp}, 8'h18);
    cyc(4);
    rst_b = 1'b1;
    t_power_fail();
    t_sequencer();
    t_test_mode();
    t_alarm();
    t_sleep();
    end_sim();
  end
endmodule
bind ccr_clock_radio ccr_clock_radio_properties #(
  .TWELVE_HOUR(TWELVE_HOUR),
  .TONE_HALF(TONE_HALF)
) ccr_props_inst (.clk(clk), .rst_b(rst_b), .view_set_low(view_set_low),
  .view_set_high(view_set_high), .advance_high(advance_high),
  .arm_low(arm_low), .arm_high(arm_high), .disp_left_q(disp_left_q),
  .disp_right_q(disp_right_q), .right_blank_q(right_blank_q),
  .colon_q(colon_q), .ap_letter_q(ap_letter_q),
  .alarm_on_ind_q(alarm_on_ind_q), .tone_out_q(tone_out_q),
  .sleep_out_q(sleep_out_q));
`default_nettype wire

// ===== ccr_key_timer.sv
// Press edge and long-hold detector for one decoded switch level
`timescale 1ns/1ps
`default_nettype none
module ccr_key_timer #(
  parameter int CW = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic level,
  input wire logic line_tick,
  input wire logic [CW-1:0] limit,
  output logic press_p,
  output logic held_long
);
  logic prev_q, prev_d;
  logic [CW-1:0] cnt_q, cnt_d;

  if (CW < 2) begin : g_cw_check
    $error("ccr_key_timer: CW too small");
  end

  always_comb begin
    prev_d = level;
    cnt_d = cnt_q;
    if (!level) begin
      cnt_d = '0;
    end else if (line_tick && cnt_q != limit) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
    end
  end

  assign press_p = level & ~prev_q;
  assign held_long = level && (cnt_q == limit);
endmodule
`default_nettype wire

// ===== ccr_panel_model.sv
// Front panel three-level switches and free-running mains line
`timescale 1ns/1ps
`default_nettype none
module ccr_panel_model (
  input wire logic clk,
  input wire logic [1:0] view_pin,
  input wire logic [1:0] adv_pin,
  input wire logic [1:0] mode_pin,
  input wire logic [1:0] arm_pin,
  output logic line_clock_input,
  output logic view_set_low,
  output logic view_set_high,
  output logic advance_low,
  output logic advance_high,
  output logic mode_low,
  output logic mode_high,
  output logic arm_low,
  output logic arm_high
);
  logic [2:0] ph = 3'h0;
  // Line edge every 8 clocks
  always @(posedge clk) ph <= ph + 3'h1;
  assign line_clock_input = ph[2];
  // Pin code 0 open, 1 low, 2 high; never both levels
  assign view_set_low = view_pin == 2'h1;
  assign view_set_high = view_pin == 2'h2;
  assign advance_low = adv_pin == 2'h1;
  assign advance_high = adv_pin == 2'h2;
  assign mode_low = mode_pin == 2'h1;
  assign mode_high = mode_pin == 2'h2;
  assign arm_low = arm_pin == 2'h1;
  assign arm_high = arm_pin == 2'h2;
endmodule
`default_nettype wire

// ===== ccr_pkg.sv
// Constants, types and operating summary for the clock radio timekeeper
// Summary of operation
// - Line input divided by 60 when rate select open, by 50 when high.
// - Alarm match sets the alarm latch; it clears itself after 59 minutes.
// - Arm select open clears the latch; held open, no alarm can occur.
// - Arm low: latch drives tone and radio; arm high: radio only.
// - Tone output lies between 400 and 2000 Hz, keyed at 2 Hz.
// - Brief view/set low, outputs idle: show alarm time, steady colon, PM.
// - View/set held past 2 s steps alarm minutes, 2 Hz or 60 Hz.
// - View/set press with outputs active snoozes tone for 8 to 9 minutes.
// - Power dip blinks display at 2 Hz, colon blank; view/set ends it.
// - View/set and advance both high: test mode, counters forced, outputs on.
// - View/set high alone: inputs ignored and all outputs off.
// - Sleep setting turns radio on; countdown to zero or view/set turns off.
// - Mode high shows sleep count; held past 2 s it decrements.
// - Mode low presses walk a six state setting sequencer.
// - Set hours shows hours with A or P; set minutes shows minutes.
// - Set left and set right show one two-digit date field, colon blank.
// - Leaving set right goes to holding if minutes changed, else run.
// - Ten idle seconds in a setting state return to run or holding.
// - Advance press in run shows date 2 s, or while held.
// - Advance held in setting steps the shown field at 2 Hz.
// - Advance high bypasses seconds: minutes step on each 1 Hz tick.
// - Colon: 1 Hz in run, steady when setting time or alarm, 2 Hz holding.
package ccr_pkg;
  localparam logic [5:0] LINE_DIV_60 = 6'h3C;
  localparam logic [5:0] LINE_DIV_50 = 6'h32;
  localparam logic [5:0] MIN_SEC_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [5:0] LATCH_MINUTES = 6'h3B;
  localparam logic [3:0] SNOOZE_MINUTES = 4'h9;
  localparam logic [3:0] IDLE_SECONDS = 4'hA;
  localparam int HOLD_SECONDS = 2;
  localparam logic [4:0] TEST_HOUR = 5'h00;
  localparam logic [5:0] TEST_MIN = 6'h00;
  localparam logic [3:0] TEST_MONTH = 4'hC;
  localparam logic [4:0] TEST_DAY = 5'h01;
  localparam logic [3:0] RESET_MONTH = 4'h1;
  localparam logic [4:0] RESET_DAY = 5'h01;
  localparam int CLK_HZ = 200000000;
  localparam int TONE_HZ = 1000;
  localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
  typedef enum logic [2:0] {
    CCR_RUN = 3'b000,
    CCR_SET_HR = 3'b001,
    CCR_SET_MIN = 3'b011,
    CCR_SET_LEFT = 3'b010,
    CCR_SET_RIGHT = 3'b110,
    CCR_HOLD = 3'b100
  } ccr_seq_t;
  typedef enum logic [1:0] {
    CCR_V_NONE = 2'b00,
    CCR_V_ALARM = 2'b01,
    CCR_V_SLEEP = 2'b11,
    CCR_V_DATE = 2'b10
  } ccr_view_t;
endpackage
